// ===== core/biow_regs.sv
// APB register bank: secondary latency, I/O window base/limit and secondary status
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module biow_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire biow_pkg::biow_events_t events_in,
  input wire biow_pkg::biow_io_req_t io_req,
  output biow_pkg::biow_io_dec_t io_dec,
  output logic [31:0] io_bottom,
  output logic [31:0] io_top
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_ph;
  logic hit_buslat;
  logic hit_iostat;
  logic hit_upper;
  logic hit_ctrl;
  logic hit_event;
  logic hit_any;
  logic [3:0] io_base_r;
  logic [3:0] io_limit_r;
  logic [15:0] io_base_up_r;
  logic [15:0] io_limit_up_r;
  logic [2:0] ctrl_r;
  logic [biow_pkg::BIOW_NUM_EV-1:0] ev_set;
  logic [biow_pkg::BIOW_NUM_EV-1:0] ev_clr;
  logic [biow_pkg::BIOW_NUM_EV-1:0] flags;
  logic [31:0] rd_nxt;
  logic [31:0] bottom_nxt;
  logic [31:0] top_nxt;
  logic in_window;

  // Answer one cycle after setup, so the access phase never has a wait state
  assign setup_ph = psel && !penable;
  assign wr_ph = psel && penable && pready && pwrite;
  assign hit_buslat = (paddr == biow_pkg::BIOW_OFF_BUSLAT);
  assign hit_iostat = (paddr == biow_pkg::BIOW_OFF_IOSTAT);
  assign hit_upper = (paddr == biow_pkg::BIOW_OFF_IOUPPER);
  assign hit_ctrl = (paddr == biow_pkg::BIOW_OFF_CTRL);
  assign hit_event = (paddr == biow_pkg::BIOW_OFF_EVENT);
  assign hit_any = hit_buslat || hit_iostat || hit_upper || hit_ctrl || hit_event;

  // ----------------------------------------------------------------
  // Handshake: pready pulses in the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup_ph;
  end

  // Unmapped addresses answer with an error, writes dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup_ph && !hit_any;
  end

  // ----------------------------------------------------------------
  // Writable window fields
  // ----------------------------------------------------------------
  // Only the upper nibbles hold state; low nibbles are constants
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_base_r <= biow_pkg::BIOW_IO_RST;
      io_limit_r <= biow_pkg::BIOW_IO_RST;
    end
    else if (wr_ph && hit_iostat)
    begin
      if (pstrb[0])
        io_base_r <= pwdata[7:4];
      if (pstrb[1])
        io_limit_r <= pwdata[15:12];
    end
  end

  // Upper address halves; stand-in for the separate upper registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_base_up_r <= biow_pkg::BIOW_UPPER_RST;
      io_limit_up_r <= biow_pkg::BIOW_UPPER_RST;
    end
    else if (wr_ph && hit_upper)
    begin
      if (pstrb[0])
        io_base_up_r[7:0] <= pwdata[7:0];
      if (pstrb[1])
        io_base_up_r[15:8] <= pwdata[15:8];
      if (pstrb[2])
        io_limit_up_r[7:0] <= pwdata[23:16];
      if (pstrb[3])
        io_limit_up_r[15:8] <= pwdata[31:24];
    end
  end

  // Enables that gate the MDPE and RSE status flags and forwarding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= biow_pkg::BIOW_CTRL_RST;
    else if (wr_ph && hit_ctrl && pstrb[0])
      ctrl_r <= pwdata[2:0];
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Hardware set terms; only MDPE and RSE are gated by their enables
  always_comb
  begin
    ev_set = '0;
    ev_set[biow_pkg::BIOW_EV_MDPE] = events_in.parity_err && ctrl_r[biow_pkg::BIOW_CTRL_PERE];
    ev_set[biow_pkg::BIOW_EV_STA] = events_in.compl_abort_sent;
    ev_set[biow_pkg::BIOW_EV_RTA] = events_in.compl_abort_rcvd;
    ev_set[biow_pkg::BIOW_EV_RMA] = events_in.unsupp_rcvd;
    ev_set[biow_pkg::BIOW_EV_RSE] = events_in.err_msg_sent && ctrl_r[biow_pkg::BIOW_CTRL_SERRE];
    ev_set[biow_pkg::BIOW_EV_DPE] = events_in.poisoned_rcvd;
  end

  // Clear terms: only W1C bits, only on a one in byte lane 3
  always_comb
  begin
    ev_clr = '0;
    if (wr_ph && hit_iostat && pstrb[3])
    begin
      ev_clr[biow_pkg::BIOW_EV_MDPE] = pwdata[biow_pkg::BIOW_ST_MDPE];
      ev_clr[biow_pkg::BIOW_EV_RSE] = pwdata[biow_pkg::BIOW_ST_RSE];
      ev_clr[biow_pkg::BIOW_EV_DPE] = pwdata[biow_pkg::BIOW_ST_DPE];
    end
    ev_clr = ev_clr & biow_pkg::BIOW_W1C_MASK;
  end

  biow_flag #(
    .N(biow_pkg::BIOW_NUM_EV)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(ev_set),
    .clr_in(ev_clr),
    .flag_r(flags)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unlisted status bits stay at zero by construction
  always_comb
  begin
    rd_nxt = '0;
    if (hit_buslat)
      rd_nxt[biow_pkg::BIOW_LAT_LSB +: 8] = biow_pkg::BIOW_LAT_VAL;
    else if (hit_iostat)
    begin
      rd_nxt[3:0] = biow_pkg::BIOW_IO32_IND;
      rd_nxt[7:4] = io_base_r;
      rd_nxt[11:8] = biow_pkg::BIOW_IO32_IND;
      rd_nxt[15:12] = io_limit_r;
      rd_nxt[biow_pkg::BIOW_ST_MDPE] = flags[biow_pkg::BIOW_EV_MDPE];
      rd_nxt[biow_pkg::BIOW_ST_STA] = flags[biow_pkg::BIOW_EV_STA];
      rd_nxt[biow_pkg::BIOW_ST_RTA] = flags[biow_pkg::BIOW_EV_RTA];
      rd_nxt[biow_pkg::BIOW_ST_RMA] = flags[biow_pkg::BIOW_EV_RMA];
      rd_nxt[biow_pkg::BIOW_ST_RSE] = flags[biow_pkg::BIOW_EV_RSE];
      rd_nxt[biow_pkg::BIOW_ST_DPE] = flags[biow_pkg::BIOW_EV_DPE];
      // Bits 16..23 and 25..26 left zero
    end
    else if (hit_upper)
      rd_nxt = {io_limit_up_r, io_base_up_r};
    else if (hit_ctrl)
      rd_nxt[2:0] = ctrl_r;
  end

  // Read data is latched at setup and held through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup_ph && !pwrite)
      prdata <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // I/O window decode
  // ----------------------------------------------------------------
  assign bottom_nxt = {io_base_up_r, io_base_r, biow_pkg::BIOW_LOW_ZERO};
  assign top_nxt = {io_limit_up_r, io_limit_r, biow_pkg::BIOW_LOW_ONES};
  assign in_window = (io_req.addr >= bottom_nxt) && (io_req.addr <= top_nxt);

  // Registered window bounds for the forwarding logic outside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      io_bottom <= '0;
      io_top <= '0;
    end
    else
    begin
      io_bottom <= bottom_nxt;
      io_top <= top_nxt;
    end
  end

  // One-cycle decision; a base above limit forwards nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      io_dec <= '0;
    else
    begin
      io_dec.valid <= io_req.valid;
      io_dec.forward <= io_req.valid && in_window && ctrl_r[biow_pkg::BIOW_CTRL_FWDEN];
    end
  end

endmodule

// ===== shared/biow_pkg.sv
// Package: offsets, field layouts, reset values and carriers for the bridge I/O window block
package biow_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] BIOW_OFF_BUSLAT = 8'h18;
  localparam logic [7:0] BIOW_OFF_IOSTAT = 8'h1c;
  localparam logic [7:0] BIOW_OFF_IOUPPER = 8'h30;
  localparam logic [7:0] BIOW_OFF_CTRL = 8'h3c;
  localparam logic [7:0] BIOW_OFF_EVENT = 8'h40;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam int BIOW_LAT_LSB = 24;
  localparam logic [7:0] BIOW_LAT_VAL = 8'h00;
  localparam logic [3:0] BIOW_IO32_IND = 4'h1;
  localparam logic [3:0] BIOW_IO_RST = 4'h0;
  localparam logic [11:0] BIOW_LOW_ZERO = 12'h000;
  localparam logic [11:0] BIOW_LOW_ONES = 12'hfff;
  localparam int BIOW_ST_MDPE = 24;
  localparam int BIOW_ST_STA = 27;
  localparam int BIOW_ST_RTA = 28;
  localparam int BIOW_ST_RMA = 29;
  localparam int BIOW_ST_RSE = 30;
  localparam int BIOW_ST_DPE = 31;
  localparam int BIOW_CTRL_PERE = 0;
  localparam int BIOW_CTRL_SERRE = 1;
  localparam int BIOW_CTRL_FWDEN = 2;
  localparam logic [2:0] BIOW_CTRL_RST = 3'h0;
  localparam logic [15:0] BIOW_UPPER_RST = 16'h0000;

  // Status flag indices inside the packed event vector
  localparam int BIOW_EV_MDPE = 0;
  localparam int BIOW_EV_STA = 1;
  localparam int BIOW_EV_RTA = 2;
  localparam int BIOW_EV_RMA = 3;
  localparam int BIOW_EV_RSE = 4;
  localparam int BIOW_EV_DPE = 5;
  localparam int BIOW_NUM_EV = 6;
  // Flags that software may clear by writing one
  localparam logic [5:0] BIOW_W1C_MASK = 6'h31;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic parity_err;
    logic compl_abort_sent;
    logic compl_abort_rcvd;
    logic unsupp_rcvd;
    logic err_msg_sent;
    logic poisoned_rcvd;
  } biow_events_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } biow_io_req_t;

  typedef struct packed {
    logic valid;
    logic forward;
  } biow_io_dec_t;

endpackage

// ===== core/biow_flag.sv
// Sticky status flag bank with set-over-clear semantics
`timescale 1ns/100ps
module biow_flag #(
  parameter int N = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  output logic [N-1:0] flag_r
);

  // ----------------------------------------------------------------
  // One sticky bit per flag
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_flag
      logic bit_r;
      // Set wins so an event in the clearing cycle is never lost
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          bit_r <= 1'b0;
        else if (set_in[gi])
          bit_r <= 1'b1;
        else if (clr_in[gi])
          bit_r <= 1'b0;
      end
      // One driver per variable: each bit has its own flop
      assign flag_r[gi] = bit_r;
    end
  endgenerate

endmodule

// ===== sim/biow_checker.sv
// Concurrent checks on the ports of the status and window bank
`timescale 1ns/100ps
module biow_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire biow_pkg::biow_io_req_t io_req,
  input wire biow_pkg::biow_io_dec_t io_dec,
  input wire logic [31:0] io_bottom,
  input wire logic [31:0] io_top
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed read and write transfers
  wire rd_done = psel && penable && pready && !pwrite;
  wire wr_done = psel && penable && pready && pwrite;

  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  property p_lat;
    rd_done && paddr == 8'h18 |-> prdata[31:24] == 8'h00;
  endproperty
  property p_ind;
    rd_done && paddr == 8'h1c |-> prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1;
  endproperty
  property p_rsv;
    rd_done && paddr == 8'h1c |-> prdata[23:16] == 8'h00 && prdata[26:25] == 2'h0;
  endproperty
  property p_bot;
    io_bottom[11:0] == 12'h000;
  endproperty
  // First edge after release still sees the reset value
  property p_top;
    $past(presetn) |-> io_top[11:0] == 12'hfff;
  endproperty
  property p_fwd;
    io_dec.forward |-> $past(io_req.valid) && $past(io_req.addr) >= io_bottom && $past(io_req.addr) <= io_top;
  endproperty
  property p_dec;
    io_req.valid |=> io_dec.valid;
  endproperty
  property p_upr;
    wr_done && paddr == 8'h30 && pstrb == 4'hf |-> ##2 io_bottom[31:16] == $past(pwdata[15:0], 2)
      && io_top[31:16] == $past(pwdata[31:16], 2);
  endproperty

  a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
  a_lat: assert property (p_lat) else $error("latency byte not zero");
  a_ind: assert property (p_ind) else $error("width nibbles not one");
  a_rsv: assert property (p_rsv) else $error("fixed status bits not zero");
  a_bot: assert property (p_bot) else $error("window bottom low bits not zero");
  a_top: assert property (p_top) else $error("window top low bits not ones");
  a_fwd: assert property (p_fwd) else $error("forward outside window");
  a_dec: assert property (p_dec) else $error("decision missing");
  a_upr: assert property (p_upr) else $error("upper window bits wrong");
  c_wr: cover property (wr_done);
  c_err: cover property (pslverr);
  c_fwd: cover property (io_dec.forward);
endmodule

// ===== sim/biow_far_end.sv
// Far-side model: raises status events and I/O transactions
`timescale 1ns/100ps
module biow_far_end (
  input wire logic pclk,
  input wire biow_pkg::biow_io_dec_t io_dec,
  output biow_pkg::biow_events_t events_in,
  output biow_pkg::biow_io_req_t io_req
);
  initial
  begin
    events_in = '0;
    io_req = '0;
  end
  // Single-cycle pulse, the shortest event the bank must catch
  task automatic pulse(input logic [5:0] ev);
    @(posedge pclk);
    events_in <= ev;
    @(posedge pclk);
    events_in <= '0;
  endtask
  // Idle address is inverted so a stale value cannot match
  task automatic probe(input logic [31:0] a, output logic fwd);
    @(posedge pclk);
    io_req <= {1'b1, a};
    @(posedge pclk);
    io_req <= {1'b0, ~a};
    @(posedge pclk);
    fwd = io_dec.forward;
  endtask
endmodule

// ===== sim/bridge_io_window_secondary_status_tb.sv
// Self-checking bench for the I/O window and secondary status bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bridge_io_window_secondary_status_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fwd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, io_bottom, io_top;
  logic [3:0] pstrb;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  biow_pkg::biow_events_t events_in;
  biow_pkg::biow_io_req_t io_req;
  biow_pkg::biow_io_dec_t io_dec;
  logic [31:0] pa [5] = '{32'h00013000, 32'h00012fff, 32'h0002ffff, 32'h00030000, 32'h00020000};
  logic pf [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK(nm, e, rd)
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk("lat", 8'h18, 32'h0);
    rchk("stat", 8'h1c, 32'h00000101);
    `CHK("top", 32'h00000fff, io_top)
    $display("test reset done");
    apb(1'b1, 8'h18, 32'hffffffff, 4'hf);
    rchk("lat", 8'h18, 32'h0);
    apb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
    rchk("stat", 8'h1c, 32'h0000f1f1);
    apb(1'b1, 8'h1c, 32'h00002030, 4'h1);
    rchk("stat", 8'h1c, 32'h0000f131);
    apb(1'b1, 8'h30, 32'h00020001, 4'hf);
    rchk("upper", 8'h30, 32'h00020001);
    `CHK("bottom", 32'h00013000, io_bottom)
    `CHK("top", 32'h0002ffff, io_top)
    $display("test window done");
    apb(1'b1, 8'h3c, 32'h4, 4'hf);
    for (int i = 0; i < 5; i++)
    begin
      far.probe(pa[i], fwd);
      `CHK("fwd", pf[i], fwd)
    end
    apb(1'b1, 8'h3c, 32'h0, 4'hf);
    far.probe(pa[0], fwd);
    `CHK("fwd", 1'b0, fwd)
    $display("test forward done");
    // Enables off: only the ungated flags may rise
    far.pulse(6'h3f);
    rchk("stat", 8'h1c, 32'hb800f131);
    apb(1'b1, 8'h3c, 32'h3, 4'hf);
    far.pulse(6'h22);
    rchk("stat", 8'h1c, 32'hf900f131);
    apb(1'b1, 8'h1c, 32'h0, 4'h8);
    rchk("stat", 8'h1c, 32'hf900f131);
    apb(1'b1, 8'h1c, 32'hff000000, 4'h8);
    rchk("stat", 8'h1c, 32'h3800f131);
    $display("test status done");
    apb(1'b0, 8'h44, 32'h0, 4'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("rdata", 32'h0, rd)
    $display("test unmapped done");
    report_and_stop();
  end

  biow_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .events_in, .io_req, .io_dec, .io_bottom, .io_top);
  biow_far_end far (.pclk, .io_dec, .events_in, .io_req);
endmodule
bind biow_regs biow_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .io_req, .io_dec, .io_bottom, .io_top);
